// File: src/adc_ctl_pkg.sv
// constants, register map and encodings for the sar adc sequencer with dma
// assumes a 10 MHz system clock and a converter core that answers with a done pulse
// Functional notes
// - converter clock divided to four selectable rates
// - sample then hold for 2/4/6/8 clocks
// - conversion lasts three windows plus thirteen clocks
// - single-shot and back-to-back continuous modes
// - sample window resets to two clocks
// - gain bit selects range of one or two references
// - reference select chooses bandgap or external pin
// - channel selector covers six inputs
// - completion raises interrupt and pollable status bit
// - optional accumulator over 2/4/8/16 samples
// - completion may wait for accumulation count
// - supply divider enabled only while measuring it
// - buffer mode triggered by one of five timers
// - results stored by dma as 16-bit words
// - buffer length at most 2047 words
// - wrap returns write pointer to buffer start
// - half-full, full, overflow interrupts individually enabled
// - each trigger converts all selected channels consecutively
package adc_ctl_pkg;
    // register offsets, byte addresses
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_CFG     = 8'h04;
    localparam logic [7:0] ADDR_STATUS  = 8'h08;
    localparam logic [7:0] ADDR_RESULT  = 8'h0C;
    localparam logic [7:0] ADDR_ACC     = 8'h10;
    localparam logic [7:0] ADDR_BUFCFG  = 8'h14;
    localparam logic [7:0] ADDR_BUFBASE = 8'h18;
    localparam logic [7:0] ADDR_BUFLEN  = 8'h1C;
    localparam logic [7:0] ADDR_BUFPTR  = 8'h20;
    localparam logic [7:0] ADDR_IRQEN   = 8'h24;
    // ctrl fields
    localparam int CTRL_START = 0;
    localparam int CTRL_CONT  = 1;
    localparam int CTRL_STOP  = 2;
    // cfg fields
    localparam int CFG_DIV_LSB  = 0;
    localparam int CFG_SMP_LSB  = 2;
    localparam int CFG_GAIN     = 4;
    localparam int CFG_REF      = 5;
    localparam int CFG_CHAN_LSB = 8;
    localparam int CFG_ACC_EN   = 12;
    localparam int CFG_ACC_LSB  = 13;
    localparam int CFG_ACC_IRQ  = 15;
    // buffer cfg fields
    localparam int BUF_EN       = 0;
    localparam int BUF_WRAP     = 1;
    localparam int BUF_TMR_LSB  = 4;
    localparam int BUF_MASK_LSB = 8;
    // status and irq bits
    localparam int ST_DONE = 0;
    localparam int ST_HALF = 1;
    localparam int ST_FULL = 2;
    localparam int ST_OVF  = 3;
    localparam int ST_BUSY = 4;
    // reset values and fixed constants
    localparam logic [1:0]  SMP_RESET    = 2'h0;
    localparam logic [10:0] BUFLEN_MAX   = 11'h7FF;
    localparam int          NUM_CHAN     = 6;
    localparam int          NUM_TIMER    = 5;
    localparam logic [2:0]  CHAN_SUPPLY  = 3'h5;
    localparam int          CONV_EXTRA   = 13;
    localparam int          SRC_MHZ      = 16;
    localparam int          SYS_MHZ      = 10;
    // enable divider period for the 2 MHz rate, in system cycles at 10 MHz
    localparam int          DIV_2MHZ     = SYS_MHZ / 2;
    // sequencer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_CONV = 4'b0010,
        ST_STORE = 4'b0100,
        ST_NEXT = 4'b1000
    } seq_e;
endpackage

// File: src/adc_conv_if.sv
// carrier between the sequencer and its timing engine
// assumes a single clock domain
`timescale 1ns/10ps
interface adc_conv_if;
    logic       start;    // one-cycle conversion request
    logic [1:0] smp_sel;  // sample window code
    logic       tick;     // converter clock enable
    logic       sampling; // sample switch closed
    logic       busy;     // conversion in flight
    logic       done;     // one-cycle end pulse
    modport seq (output start, output smp_sel, input tick, input sampling, input busy, input done);
    modport eng (input start, input smp_sel, output tick, output sampling, output busy, output done);
endinterface

// File: src/adc_clk_div.sv
// converter clock enable divider
// assumes clk_sys as the only clock; rates are scaled onto it as enable pulses
`timescale 1ns/10ps
module adc_clk_div #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    // rate select: 0 2MHz,1 1MHz,2 500kHz,3 250kHz
    input  wire logic [1:0] div_sel,
    // enable out
    output logic            tick
);
    logic [W-1:0] cnt_q;  // cycle counter
    logic [W-1:0] lim;    // terminal count
    // rate 2 MHz is five system cycles, each step doubles it
    always_comb begin
        lim = W'((adc_ctl_pkg::DIV_2MHZ << div_sel) - 1);
    end
    // free running counter with pulse at wrap
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end else if (cnt_q >= lim) begin
            cnt_q <= '0;
            tick  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 1'b1;
            tick  <= 1'b0;
        end
    end
endmodule

// File: src/adc_conv_timer.sv
// one conversion: sample window then hold and approximation clocks
// assumes tick is a one-cycle converter clock enable
`timescale 1ns/10ps
module adc_conv_timer (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // sequencer side
    adc_conv_if.eng  cv
);
    logic [5:0] cnt_q;    // converter clocks elapsed
    logic [5:0] smp_len;  // sample window length
    logic [5:0] total;    // whole conversion length
    // window 2/4/6/8 and total 3*window+13
    always_comb begin
        smp_len = 6'({cv.smp_sel, 1'b0}) + 6'h2;
        total   = 6'(smp_len * 3 + adc_ctl_pkg::CONV_EXTRA);
    end
    assign cv.sampling = cv.busy && (cnt_q < smp_len);
    // count converter clocks while busy
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt_q   <= '0;
            cv.busy <= 1'b0;
            cv.done <= 1'b0;
        end else begin
            cv.done <= 1'b0;
            if (!cv.busy) begin
                if (cv.start) begin
                    cv.busy <= 1'b1;
                    cnt_q   <= '0;
                end
            end else if (cv.tick) begin
                if (cnt_q == total - 1'b1) begin
                    cv.busy <= 1'b0;
                    cv.done <= 1'b1;
                end
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end
endmodule

// File: src/sar_adc_sequencer_dma.sv
// top: registers, sequencer, accumulator and dma write engine
// assumes analogue core returns a 10-bit result valid at conv_done; dma bus never stalls
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/10ps
module sar_adc_sequencer_dma (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    // timer triggers
    input  wire logic [4:0]  timer_trig,
    // analogue core
    input  wire logic [9:0]  ana_result,
    output logic [2:0]       ana_chan,
    output logic             ana_gain,
    output logic             ana_ref_ext,
    output logic             ana_sample,
    output logic             ana_clk_en,
    output logic             ana_supply_div_en,
    // dma write port
    output logic             dma_wr,
    output logic [15:0]      dma_addr,
    output logic [15:0]      dma_wdata,
    // interrupt
    output logic             irq
);
    adc_conv_if cv();
    // config registers
    logic [1:0]  div_q;       // clock divider code
    logic [1:0]  smp_q;       // sample window code
    logic        gain_q;      // input range
    logic        ref_q;       // reference select
    logic [2:0]  chan_q;      // single mode channel
    logic        acc_en_q;    // accumulator on
    logic [1:0]  acc_cnt_q;   // 2/4/8/16 code
    logic        acc_irq_q;   // done waits for count
    logic        cont_q;      // continuous mode
    logic        buf_en_q;    // buffer mode
    logic        wrap_q;      // wrap at full
    logic [2:0]  tmr_q;       // trigger timer
    logic [5:0]  mask_q;      // buffer channel set
    logic [15:0] base_q;      // buffer base byte address
    logic [10:0] len_q;       // buffer length in words
    logic [3:0]  irqen_q;     // irq enables
    // state
    adc_ctl_pkg::seq_e st_q;  // sequencer state
    logic [3:0]  sticky_q;    // done/half/full/ovf
    logic [9:0]  result_q;    // last result
    logic [13:0] acc_q;       // accumulated sum
    logic [13:0] acc_out_q;   // completed sum
    logic [4:0]  acc_n_q;     // samples in period
    logic [10:0] fill_q;      // words in buffer
    logic [2:0]  cur_q;       // channel converting
    logic        trig_q;      // previous trigger level
    logic [3:0]  ev;          // events this cycle
    logic        trig_rise;   // selected trigger edge
    logic [4:0]  acc_target;  // accumulation count
    logic        last_chan;   // no higher channel in mask
    logic [2:0]  next_chan;   // next mask channel
    logic        full_now;    // buffer holds len words

    // next set channel above current, first set channel if from seven
    function automatic logic [3:0] find_chan(input logic [5:0] m, input logic [2:0] from);
        logic [3:0] r;
        r = 4'h8;
        for (int i = adc_ctl_pkg::NUM_CHAN - 1; i >= 0; i--) begin
            if (m[i] && (from == 3'h7 || 3'(i) > from)) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    adc_clk_div u_div (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .div_sel (div_q),
        .tick    (cv.tick)
    );
    adc_conv_timer u_tmr (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .cv      (cv.eng)
    );

    assign cv.smp_sel = smp_q;
    assign ana_clk_en = cv.tick;
    assign ana_sample = cv.sampling;
    assign ana_gain    = gain_q;
    assign ana_ref_ext = ref_q;
    assign ana_chan    = buf_en_q ? cur_q : chan_q;
    assign ana_supply_div_en = cv.busy && (ana_chan == adc_ctl_pkg::CHAN_SUPPLY);
    assign trig_rise  = timer_trig[tmr_q] && !trig_q;
    assign acc_target = 5'h2 << acc_cnt_q;
    assign {last_chan, next_chan} = find_chan(mask_q, cur_q);
    assign full_now   = (fill_q == len_q);
    assign cv.start   = (st_q == adc_ctl_pkg::ST_NEXT);
    assign irq        = |(sticky_q & irqen_q);

    // configuration writes
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            div_q <= 2'h0;
            smp_q <= adc_ctl_pkg::SMP_RESET;
            gain_q <= 1'b0;
            ref_q <= 1'b0;
            chan_q <= 3'h0;
            acc_en_q <= 1'b0;
            acc_cnt_q <= 2'h0;
            acc_irq_q <= 1'b0;
            buf_en_q <= 1'b0;
            wrap_q <= 1'b0;
            tmr_q <= 3'h0;
            mask_q <= 6'h00;
            base_q <= 16'h0000;
            len_q <= adc_ctl_pkg::BUFLEN_MAX;
            irqen_q <= 4'h0;
        end else if (reg_wr) begin
            if (reg_addr == adc_ctl_pkg::ADDR_CFG) begin
                div_q <= reg_wdata[adc_ctl_pkg::CFG_DIV_LSB +: 2];
                smp_q <= reg_wdata[adc_ctl_pkg::CFG_SMP_LSB +: 2];
                gain_q <= reg_wdata[adc_ctl_pkg::CFG_GAIN];
                ref_q <= reg_wdata[adc_ctl_pkg::CFG_REF];
                chan_q <= (reg_wdata[adc_ctl_pkg::CFG_CHAN_LSB +: 3] > 3'h5) ? 3'h5
                          : reg_wdata[adc_ctl_pkg::CFG_CHAN_LSB +: 3];
                acc_en_q <= reg_wdata[adc_ctl_pkg::CFG_ACC_EN];
                acc_cnt_q <= reg_wdata[adc_ctl_pkg::CFG_ACC_LSB +: 2];
                acc_irq_q <= reg_wdata[adc_ctl_pkg::CFG_ACC_IRQ];
            end else if (reg_addr == adc_ctl_pkg::ADDR_BUFCFG) begin
                buf_en_q <= reg_wdata[adc_ctl_pkg::BUF_EN];
                wrap_q <= reg_wdata[adc_ctl_pkg::BUF_WRAP];
                tmr_q <= (reg_wdata[adc_ctl_pkg::BUF_TMR_LSB +: 3] > 3'h4) ? 3'h4
                         : reg_wdata[adc_ctl_pkg::BUF_TMR_LSB +: 3];
                mask_q <= reg_wdata[adc_ctl_pkg::BUF_MASK_LSB +: 6];
            end else if (reg_addr == adc_ctl_pkg::ADDR_BUFBASE) begin
                base_q <= {reg_wdata[15:1], 1'b0};
            end else if (reg_addr == adc_ctl_pkg::ADDR_BUFLEN) begin
                len_q <= (reg_wdata[10:0] == 11'h000) ? 11'h001 : reg_wdata[10:0];
            end else if (reg_addr == adc_ctl_pkg::ADDR_IRQEN) begin
                irqen_q <= reg_wdata[3:0];
            end
        end
    end

    // trigger edge memory
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            trig_q <= 1'b0;
        end else begin
            trig_q <= timer_trig[tmr_q];
        end
    end

    // continuous flag: set by start with cont, cleared by stop
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cont_q <= 1'b0;
        end else if (reg_wr && reg_addr == adc_ctl_pkg::ADDR_CTRL) begin
            if (reg_wdata[adc_ctl_pkg::CTRL_STOP]) begin
                cont_q <= 1'b0;
            end else if (reg_wdata[adc_ctl_pkg::CTRL_START]) begin
                cont_q <= reg_wdata[adc_ctl_pkg::CTRL_CONT];
            end
        end
    end

    // sequencer
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_q <= adc_ctl_pkg::ST_IDLE;
            cur_q <= 3'h0;
        end else begin
            case (st_q)
                adc_ctl_pkg::ST_IDLE: begin
                    if (buf_en_q && trig_rise && mask_q != 6'h00) begin
                        cur_q <= 3'(find_chan(mask_q, 3'h7));
                        st_q <= adc_ctl_pkg::ST_NEXT;
                    end else if (!buf_en_q && reg_wr && reg_addr == adc_ctl_pkg::ADDR_CTRL
                                 && reg_wdata[adc_ctl_pkg::CTRL_START]) begin
                        st_q <= adc_ctl_pkg::ST_NEXT;
                    end
                end
                adc_ctl_pkg::ST_NEXT: begin
                    st_q <= adc_ctl_pkg::ST_CONV;
                end
                adc_ctl_pkg::ST_CONV: begin
                    if (cv.done) begin
                        st_q <= adc_ctl_pkg::ST_STORE;
                    end
                end
                adc_ctl_pkg::ST_STORE: begin
                    if (buf_en_q && !last_chan) begin
                        cur_q <= next_chan;
                        st_q <= adc_ctl_pkg::ST_NEXT;
                    end else if (!buf_en_q && cont_q) begin
                        st_q <= adc_ctl_pkg::ST_NEXT;
                    end else begin
                        st_q <= adc_ctl_pkg::ST_IDLE;
                    end
                end
                default: begin
                    st_q <= adc_ctl_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // result capture and accumulator
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            result_q <= 10'h000;
            acc_q <= 14'h0000;
            acc_out_q <= 14'h0000;
            acc_n_q <= 5'h00;
        end else if (cv.done) begin
            result_q <= ana_result;
            if (acc_en_q) begin
                if (acc_n_q + 1'b1 >= acc_target) begin
                    acc_out_q <= acc_q + 14'(ana_result);
                    acc_q <= 14'h0000;
                    acc_n_q <= 5'h00;
                end else begin
                    acc_q <= acc_q + 14'(ana_result);
                    acc_n_q <= acc_n_q + 1'b1;
                end
            end
        end else if (!acc_en_q) begin
            acc_q <= 14'h0000;
            acc_n_q <= 5'h00;
        end
    end

    // dma writes: one word per result in buffer mode, none once full with wrap off
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            dma_wr <= 1'b0;
            dma_addr <= 16'h0000;
            dma_wdata <= 16'h0000;
            fill_q <= 11'h000;
        end else begin
            dma_wr <= 1'b0;
            if (!buf_en_q) begin
                fill_q <= 11'h000;
                dma_addr <= base_q;
            end else if (cv.done) begin
                if (!full_now || wrap_q) begin
                    dma_wr <= 1'b1;
                    dma_wdata <= {6'h00, ana_result};
                    if (full_now) begin
                        dma_addr <= base_q;
                        fill_q <= 11'h001;
                    end else begin
                        dma_addr <= (fill_q == 11'h000) ? base_q
                                    : dma_addr + 16'h0002;
                        fill_q <= fill_q + 1'b1;
                    end
                end
            end
        end
    end

    // event decode for sticky flags
    always_comb begin
        ev = 4'h0;
        ev[adc_ctl_pkg::ST_DONE] = cv.done && (!acc_en_q || !acc_irq_q
                                   || acc_n_q + 1'b1 >= acc_target);
        ev[adc_ctl_pkg::ST_HALF] = buf_en_q && cv.done && !full_now && (fill_q + 1'b1 == (len_q >> 1));
        ev[adc_ctl_pkg::ST_FULL] = buf_en_q && cv.done && !full_now && (fill_q + 1'b1 == len_q);
        ev[adc_ctl_pkg::ST_OVF]  = buf_en_q && cv.done && full_now && !wrap_q;
    end

    // sticky flags: write one to clear, set wins
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sticky_q <= 4'h0;
        end else begin
            if (reg_wr && reg_addr == adc_ctl_pkg::ADDR_STATUS) begin
                sticky_q <= (sticky_q & ~reg_wdata[3:0]) | ev;
            end else begin
                sticky_q <= sticky_q | ev;
            end
        end
    end

    // read data, one cycle after strobe
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            if (reg_addr == adc_ctl_pkg::ADDR_CFG) begin
                reg_rdata <= {16'h0000, acc_irq_q, acc_cnt_q, acc_en_q, 1'b0, chan_q,
                              2'h0, ref_q, gain_q, smp_q, div_q};
            end else if (reg_addr == adc_ctl_pkg::ADDR_CTRL) begin
                reg_rdata <= {30'h0, cont_q, 1'b0};
            end else if (reg_addr == adc_ctl_pkg::ADDR_STATUS) begin
                reg_rdata <= {27'h0, (st_q != adc_ctl_pkg::ST_IDLE), sticky_q};
            end else if (reg_addr == adc_ctl_pkg::ADDR_RESULT) begin
                reg_rdata <= {22'h0, result_q};
            end else if (reg_addr == adc_ctl_pkg::ADDR_ACC) begin
                reg_rdata <= {18'h0, acc_out_q};
            end else if (reg_addr == adc_ctl_pkg::ADDR_BUFCFG) begin
                reg_rdata <= {18'h0, mask_q, 1'b0, tmr_q, 2'h0, wrap_q, buf_en_q};
            end else if (reg_addr == adc_ctl_pkg::ADDR_BUFBASE) begin
                reg_rdata <= {16'h0000, base_q};
            end else if (reg_addr == adc_ctl_pkg::ADDR_BUFLEN) begin
                reg_rdata <= {21'h0, len_q};
            end else if (reg_addr == adc_ctl_pkg::ADDR_BUFPTR) begin
                reg_rdata <= {5'h00, fill_q, dma_addr};
            end else if (reg_addr == adc_ctl_pkg::ADDR_IRQEN) begin
                reg_rdata <= {28'h0, irqen_q};
            end else begin
                reg_rdata <= 32'h00000000;
            end
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end
endmodule

// File: verification/adc_core_model.sv
// analogue core model: converter plus input multiplexer
// assumes the design samples ana_result in the cycle its conversion ends
`timescale 1ns/10ps
module adc_core_model (
    // converter side
    input  wire logic       clk_sys,
    input  wire logic [2:0] ana_chan,
    input  wire logic       ana_gain,
    input  wire logic       ana_ref_ext,
    input  wire logic       ana_sample,
    output logic [9:0]      ana_result
);
    // track the selected input while sampling, hold the code once the switch opens
    always @(posedge clk_sys) begin
        if (ana_sample) begin
            ana_result <= {ana_chan, ana_gain, ana_ref_ext, 5'h15};
        end
    end
endmodule

// File: verification/sar_adc_sequencer_dma_properties.sv
// checker on the top ports of the adc sequencer
// assumes one clock domain and an active-low asynchronous reset
`timescale 1ns/10ps
module sar_adc_sequencer_dma_properties (
    // watched ports
    input wire logic        clk_sys,
    input wire logic        nrst,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [2:0]  ana_chan,
    input wire logic        ana_sample,
    input wire logic        ana_clk_en,
    input wire logic        ana_supply_div_en,
    input wire logic        dma_wr,
    input wire logic [15:0] dma_addr,
    input wire logic [15:0] dma_wdata
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // fastest converter rate leaves four idle cycles
    sequence gap_s;
        !ana_clk_en [*4];
    endsequence
    a_clk_gap: assert property (ana_clk_en |=> gap_s) else $error("enable too close");
    a_supply_div: assert property (ana_supply_div_en |-> ana_chan == 3'h5) else $error("divider on");
    a_div_on: assert property (ana_sample |-> ana_supply_div_en == (ana_chan == 3'h5)) else $error("div");
    a_chan_range: assert property (ana_chan <= 3'h5) else $error("bad channel");
    a_chan_held: assert property (ana_sample && $past(ana_sample) |-> $stable(ana_chan)) else $error("mux moved");
    a_dma_word: assert property (dma_wr |-> dma_wdata[15:10] == 6'h00 && !dma_addr[0]) else $error("bad word");
    a_dma_single: assert property (dma_wr |=> !dma_wr) else $error("double store");
    a_dma_idle: assert property (dma_wr |-> !ana_sample) else $error("store while sampling");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("stray read data");
endmodule
bind sar_adc_sequencer_dma sar_adc_sequencer_dma_properties u_props (.clk_sys(clk_sys), .nrst(nrst),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ana_chan(ana_chan), .ana_sample(ana_sample),
    .ana_clk_en(ana_clk_en), .ana_supply_div_en(ana_supply_div_en), .dma_wr(dma_wr),
    .dma_addr(dma_addr), .dma_wdata(dma_wdata));

// File: verification/sar_adc_sequencer_dma_bench.sv
// bench: single conversions, reset, buffer mode, accumulator, continuous mode
// assumes the core model beside the design and a 10 MHz clock
`timescale 1ns/10ps
module sar_adc_sequencer_dma_bench;
    typedef struct packed {logic [1:0] dv; logic [1:0] sm; logic [2:0] ch; logic g; logic r; logic [5:0] n;} row_s;
    logic        clk_sys = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;  // clock, reset, strobes
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
    logic [4:0]  timer_trig = 5'h00;
    logic [9:0]  ana_result;
    logic [2:0]  ana_chan;
    logic        ana_gain, ana_ref_ext, ana_sample, ana_clk_en, ana_supply_div_en, dma_wr, irq;
    logic [15:0] dma_addr, dma_wdata;
    logic [31:0] dq[$];  // stored dma words
    int          miscompares = 0, comparisons = 0, ticks = 0, k, j;
    // rate, window, channel, gain, reference, expected tick count
    row_s rows[6] = '{'{0, 0, 0, 0, 0, 19}, '{1, 1, 1, 1, 0, 25}, '{2, 2, 2, 0, 1, 31},
                      '{3, 3, 3, 1, 1, 37}, '{0, 1, 4, 0, 0, 25}, '{1, 0, 5, 1, 0, 19}};
    sar_adc_sequencer_dma u_sar_adc_sequencer_dma (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_trig(timer_trig),
        .ana_result(ana_result), .ana_chan(ana_chan), .ana_gain(ana_gain), .ana_ref_ext(ana_ref_ext),
        .ana_sample(ana_sample), .ana_clk_en(ana_clk_en), .ana_supply_div_en(ana_supply_div_en),
        .dma_wr(dma_wr), .dma_addr(dma_addr), .dma_wdata(dma_wdata), .irq(irq));
    adc_core_model u_adc_core_model (.clk_sys(clk_sys), .ana_chan(ana_chan), .ana_gain(ana_gain),
        .ana_ref_ext(ana_ref_ext), .ana_sample(ana_sample), .ana_result(ana_result));
    always #50 clk_sys = ~clk_sys;
    // count converter ticks and collect stored words
    always @(posedge clk_sys) begin
        if (ana_clk_en) ticks <= ticks + 1;
        if (dma_wr) dq.push_back({dma_addr, dma_wdata});
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic wait_irq;
        @(posedge clk_sys);
        for (k = 0; k < 2000 && irq !== 1'b1; k++) @(posedge clk_sys);
        #1 chk({31'h0, irq}, 32'h1);
    endtask
    task automatic pulse(input int t);
        @(posedge clk_sys);
        timer_trig[t] <= 1'b1;
        @(posedge clk_sys);
        timer_trig <= 5'h00;
        repeat (400) @(posedge clk_sys);  // two conversions fit well inside
    endtask
    task automatic complete_run;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // watchdog well beyond the expected run
    initial begin
        #3000000;
        miscompares++;
        complete_run;
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        wr(adc_ctl_pkg::ADDR_IRQEN, 32'h1);
        foreach (rows[i]) begin
            wr(adc_ctl_pkg::ADDR_CFG, {21'h0, rows[i].ch, 2'b00, rows[i].r, rows[i].g, rows[i].sm, rows[i].dv});
            wr(adc_ctl_pkg::ADDR_CTRL, 32'h1);
            @(posedge clk_sys) #1 ticks = 0;  // timer counts from the edge after start
            wait_irq;
            chk(ticks, {26'h0, rows[i].n});
            rd(adc_ctl_pkg::ADDR_STATUS, d);
            chk({31'h0, d[0]}, 32'h1);
            rd(adc_ctl_pkg::ADDR_RESULT, d);
            chk({22'h0, d[9:0]}, {22'h0, rows[i].ch, rows[i].g, rows[i].r, 5'h15});
            wr(adc_ctl_pkg::ADDR_STATUS, 32'h1F);
            $display("conversion row %0d finished", i);
        end
        // second reset in mid-run
        @(posedge clk_sys);
        nrst <= 1'b0;
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        rd(adc_ctl_pkg::ADDR_CFG, d);
        chk({30'h0, d[3:2]}, 32'h0);
        rd(adc_ctl_pkg::ADDR_BUFLEN, d);
        chk({21'h0, d[10:0]}, 32'h7FF);
        $display("reset test finished");
        // buffer of four words, channels 0 and 1, timer 3
        wr(adc_ctl_pkg::ADDR_BUFBASE, 32'h100);
        wr(adc_ctl_pkg::ADDR_BUFLEN, 32'h4);
        wr(adc_ctl_pkg::ADDR_IRQEN, 32'hE);
        wr(adc_ctl_pkg::ADDR_BUFCFG, 32'h331);
        pulse(1);
        chk(dq.size(), 0);
        for (j = 0; j < 3; j++) begin
            pulse(3);
            rd(adc_ctl_pkg::ADDR_STATUS, d);
            chk({29'h0, d[3:1]}, (2 << j) - 1);
        end
        chk(dq.size(), 4);
        for (j = 0; j < 4; j++) chk(dq[j], {16'h100 + 16'(2 * j), 6'h0, 3'(j % 2), 7'h15});
        wr(adc_ctl_pkg::ADDR_BUFCFG, 32'h333);  // wrap on, buffer still full
        pulse(3);
        chk(dq[4], {16'h0100, 16'h0015});
        chk(dq[5], {16'h0102, 16'h0095});
        chk({31'h0, irq}, 32'h1);
        wr(adc_ctl_pkg::ADDR_IRQEN, 32'h0);
        #1 chk({31'h0, irq}, 32'h0);
        $display("buffer test finished");
        // accumulate two samples of channel 2, done held back
        wr(adc_ctl_pkg::ADDR_BUFCFG, 32'h0);
        wr(adc_ctl_pkg::ADDR_STATUS, 32'h1F);
        wr(adc_ctl_pkg::ADDR_IRQEN, 32'h1);
        wr(adc_ctl_pkg::ADDR_CFG, 32'h9200);
        wr(adc_ctl_pkg::ADDR_CTRL, 32'h1);
        repeat (200) @(posedge clk_sys);
        rd(adc_ctl_pkg::ADDR_STATUS, d);
        chk({31'h0, d[0]}, 32'h0);
        wr(adc_ctl_pkg::ADDR_CTRL, 32'h1);
        wait_irq;
        rd(adc_ctl_pkg::ADDR_ACC, d);
        chk({18'h0, d[13:0]}, 32'h22A);
        // continuous: second done with no second start
        wr(adc_ctl_pkg::ADDR_CFG, 32'h0200);
        wr(adc_ctl_pkg::ADDR_STATUS, 32'h1F);
        wr(adc_ctl_pkg::ADDR_CTRL, 32'h3);
        wait_irq;
        wr(adc_ctl_pkg::ADDR_STATUS, 32'h1F);
        wait_irq;
        chk({31'h0, irq}, 32'h1);
        wr(adc_ctl_pkg::ADDR_CTRL, 32'h4);
        $display("accumulator and continuous tests finished");
        complete_run;
    end
endmodule
